// File: core/fifo_meta_event_inserter_defs.svh
`ifndef FIFO_META_EVENT_INSERTER_DEFS_SVH
`define FIFO_META_EVENT_INSERTER_DEFS_SVH

`define REG_WAKE_EN        8'h00
`define REG_WAKE_IRQ_EN    8'h04
`define REG_NWAKE_EN       8'h08
`define REG_NWAKE_IRQ_EN   8'h0C
`define REG_FLUSH          8'h10
`define REG_WATERMARK      8'h14
`define REG_STATUS         8'h18

`define WAKE_EN_RST        17'h1_B816
`define WAKE_IRQ_EN_RST    17'h1_0810
`define NWAKE_EN_RST       17'h1_A816
`define NWAKE_IRQ_EN_RST   17'h1_8810
`define LEGAL_TYPE_MASK    17'h1_F81E

`define EV_FLUSH_DONE      8'h01
`define EV_RATE_CHANGED    8'h02
`define EV_POWER_CHANGED   8'h03
`define EV_FW_ERROR        8'h04
`define EV_SENSOR_ERROR    8'h0B
`define EV_OVERFLOW        8'h0C
`define EV_RANGE_CHANGED   8'h0D
`define EV_WATERMARK       8'h0E
`define EV_SELF_TEST       8'h0F
`define EV_INITIALIZED     8'h10

`define ST_ID_ACCEL        8'h01
`define ST_ID_MAG_UNCAL    8'h0E
`define ST_ID_GYRO_UNCAL   8'h10

`define FLUSH_WAKE_BIT     8
`define WM_WAKE_BIT        16
`define DISCARD_BYTES      16'h00C8
`define LOSS_MAX           16'hFFFF

`endif

// File: core/fifo_meta_event_pkg.sv
package fifo_meta_event_pkg;

  typedef struct packed {
    logic       wake;
    logic [7:0] etype;
    logic [7:0] b1;
    logic [7:0] b2;
  } ev_req_t;

  typedef struct packed {
    logic        wake;
    logic [31:0] ts;
  } sample_req_t;

  typedef struct packed {
    logic       wake;
    logic [7:0] sensor;
    logic [2:0] fail;
  } self_test_t;

  typedef struct packed {
    logic       wake;
    logic [7:0] data;
    logic       last;
  } out_byte_t;

  typedef enum logic [1:0] {REC_NONE, REC_HI, REC_LO, REC_EVT} rec_kind_t;
  typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_SEND, ST_GRANT} state_t;
  typedef enum logic [2:0] {JOB_NONE, JOB_INIT, JOB_OVF, JOB_FLUSH, JOB_WM, JOB_EVT, JOB_ST, JOB_SAMPLE} job_t;

endpackage : fifo_meta_event_pkg

// File: core/fifo_meta_event_inserter.sv
// Behaviour
// [RQ1] Each event type has its own enable; disabled types never reach the FIFO.
// [RQ2] Each event type has its own interrupt enable, raising the host interrupt alone; the code raises it only for an event its FIFO enable lets through.
// [RQ3] After initialization, timestamp then Initialized event (type 16) with RAM version bytes.
// [RQ4] Every flush request inserts Flush Complete (type 1) carrying the flushed sensor type; the code keeps one pending flush that a new write replaces.
// [RQ5] Rate changes emit type 2 with the sensor type in byte 1.
// [RQ6] Power up or down emits type 3 with sensor type and power mode.
// [RQ7] Firmware errors emit type 4 with error register and debug state.
// [RQ8] Host logs error payload and recovers only by reset, patch reload, reconfiguration.
// [RQ9] Sensor failures emit type 11 with sensor type and status bits.
// [RQ10] Data loss emits type 12 with saturating lost byte count, low then high.
// [RQ11] High then low timestamp records follow every overflow event.
// [RQ12] Overflow detection discards about 200 oldest bytes of the FIFO; the code discards only when no overflow is already pending.
// [RQ13] Range changes emit type 13 with sensor type once they take effect.
// [RQ14] Watermark event type 14 carries remaining byte count near the watermark.
// [RQ15] Self-test event type 15 names the accelerometer, uncalibrated gyro or magnetometer.
// [RQ16] Self-test byte 2 holds failed axes, X=1, Y=2, Z=4, zero passes.
// [RQ17] Enables and interrupt enables are kept per FIFO with documented defaults.
// [RQ18] Low timestamp record precedes a sample only when its low half changed; the code also writes it while no low record has gone to its FIFO since reset.
// [RQ19] High timestamp record is written when the sample's upper half changed.
// [RQ20] After overflow, the event is placed when the host resumes reading.
// [RQ21] Host interrupt is raised whenever an interrupt-enabled event is emitted.
// [RQ22] Type zero and reserved types five to ten are never emitted.
`timescale 1ns/100ps
`include "fifo_meta_event_inserter_defs.svh"

module fifo_meta_event_inserter #(
  parameter logic [7:0] TS_HI_ID      = 8'hF0,
  parameter logic [7:0] TS_LO_ID      = 8'hF1,
  parameter logic [7:0] META_WAKE_ID  = 8'hF2,
  parameter logic [7:0] META_NWAKE_ID = 8'hF3
) (
  input  wire logic                              clk_i,
  input  wire logic                              rst_n_i,
  input  wire logic [7:0]                        reg_addr_i,
  input  wire logic [31:0]                       reg_wdata_i,
  input  wire logic                              reg_we_i,
  input  wire logic                              reg_re_i,
  output logic      [31:0]                       reg_rdata_o,
  input  wire logic                              init_done_i,
  input  wire logic [15:0]                       ram_version_i,
  input  wire logic [31:0]                       cur_ts_i,
  input  wire logic                              ev_valid_i,
  input  wire fifo_meta_event_pkg::ev_req_t      ev_i,
  output logic                                   ev_ready_o,
  input  wire logic                              st_valid_i,
  input  wire fifo_meta_event_pkg::self_test_t   st_i,
  output logic                                   st_ready_o,
  input  wire logic                              sample_valid_i,
  input  wire fifo_meta_event_pkg::sample_req_t  sample_i,
  output logic                                   sample_ready_o,
  input  wire logic                              data_lost_i,
  input  wire logic [15:0]                       lost_bytes_i,
  input  wire logic                              ovf_wake_i,
  input  wire logic                              host_reading_i,
  input  wire logic [15:0]                       fifo_level_i,
  output logic                                   discard_o,
  output logic      [15:0]                       discard_bytes_o,
  output fifo_meta_event_pkg::out_byte_t         out_o,
  output logic                                   out_valid_o,
  input  wire logic                              out_ready_i,
  output logic                                   host_irq_o
);

  function automatic logic mask_bit(input logic [16:0] mask, input logic [7:0] t);
    mask_bit = (t <= 8'h10) && mask[t[4:0]];
  endfunction : mask_bit

  function automatic logic gen_type_ok(input logic [7:0] t);
    gen_type_ok = (t == `EV_RATE_CHANGED) || (t == `EV_POWER_CHANGED) || (t == `EV_FW_ERROR) ||
                  (t == `EV_SENSOR_ERROR) || (t == `EV_RANGE_CHANGED);
  endfunction : gen_type_ok

  logic [16:0]                     wake_en;
  logic [16:0]                     wake_irq_en;
  logic [16:0]                     nwake_en;
  logic [16:0]                     nwake_irq_en;
  logic [15:0]                     wm_level;
  logic                            wm_wake;
  logic                            wm_armed;
  logic                            flush_pend;
  logic [7:0]                      flush_sensor;
  logic                            flush_wake;
  logic                            ovf_pend;
  logic                            ovf_wake;
  logic [15:0]                     loss_cnt;
  logic                            init_sent;
  logic [15:0]                     last_hi [2];
  logic [15:0]                     last_lo [2];
  logic [1:0]                      hi_valid;
  logic [1:0]                      lo_valid;
  fifo_meta_event_pkg::state_t     state;
  fifo_meta_event_pkg::job_t       job;
  fifo_meta_event_pkg::job_t       next_job;
  fifo_meta_event_pkg::rec_kind_t  seq [3];
  logic [31:0]                     rec_sr;
  logic [2:0]                      rec_left;
  logic                            rec_is_evt;
  logic                            job_wake;
  logic [31:0]                     job_ts;
  logic [7:0]                      job_type;
  logic [7:0]                      job_b1;
  logic [7:0]                      job_b2;
  logic                            job_irq;
  logic                            take;
  logic                            send_done;
  logic [16:0]                     sel_en;
  logic [16:0]                     sel_irq;
  logic                            sel_wake;
  logic [16:0]                     sum_loss;

  assign take      = (state == fifo_meta_event_pkg::ST_IDLE) && (next_job != fifo_meta_event_pkg::JOB_NONE);
  assign send_done = (state == fifo_meta_event_pkg::ST_SEND) && out_ready_i && (rec_left == 3'd1);

  always_comb begin
    next_job = fifo_meta_event_pkg::JOB_NONE;
    if (!init_sent) begin
      if (init_done_i) begin
        next_job = fifo_meta_event_pkg::JOB_INIT; // [RQ3]
      end
    end else if (ovf_pend && host_reading_i) begin
      next_job = fifo_meta_event_pkg::JOB_OVF; // [RQ20]
    end else if (flush_pend) begin
      next_job = fifo_meta_event_pkg::JOB_FLUSH;
    end else if (wm_armed && (wm_level != 16'h0000) && (fifo_level_i >= wm_level)) begin
      next_job = fifo_meta_event_pkg::JOB_WM;
    end else if (ev_valid_i) begin
      next_job = fifo_meta_event_pkg::JOB_EVT;
    end else if (st_valid_i) begin
      next_job = fifo_meta_event_pkg::JOB_ST;
    end else if (sample_valid_i) begin
      next_job = fifo_meta_event_pkg::JOB_SAMPLE;
    end
  end

  assign ev_ready_o     = take && (next_job == fifo_meta_event_pkg::JOB_EVT);
  assign st_ready_o     = take && (next_job == fifo_meta_event_pkg::JOB_ST);
  assign sample_ready_o = (state == fifo_meta_event_pkg::ST_GRANT);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wake_en      <= `WAKE_EN_RST; // [RQ17]
      wake_irq_en  <= `WAKE_IRQ_EN_RST;
      nwake_en     <= `NWAKE_EN_RST;
      nwake_irq_en <= `NWAKE_IRQ_EN_RST;
      wm_level     <= 16'h0000;
      wm_wake      <= 1'b0;
    end else if (reg_we_i) begin
      case (reg_addr_i)
        `REG_WAKE_EN:      wake_en      <= reg_wdata_i[16:0] & `LEGAL_TYPE_MASK; // [RQ1] [RQ22]
        `REG_WAKE_IRQ_EN:  wake_irq_en  <= reg_wdata_i[16:0] & `LEGAL_TYPE_MASK; // [RQ2]
        `REG_NWAKE_EN:     nwake_en     <= reg_wdata_i[16:0] & `LEGAL_TYPE_MASK;
        `REG_NWAKE_IRQ_EN: nwake_irq_en <= reg_wdata_i[16:0] & `LEGAL_TYPE_MASK;
        `REG_WATERMARK: begin
          wm_level <= reg_wdata_i[15:0];
          wm_wake  <= reg_wdata_i[`WM_WAKE_BIT];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_re_i) begin
      case (reg_addr_i)
        `REG_WAKE_EN:      reg_rdata_o <= {15'h0000, wake_en};
        `REG_WAKE_IRQ_EN:  reg_rdata_o <= {15'h0000, wake_irq_en};
        `REG_NWAKE_EN:     reg_rdata_o <= {15'h0000, nwake_en};
        `REG_NWAKE_IRQ_EN: reg_rdata_o <= {15'h0000, nwake_irq_en};
        `REG_FLUSH:        reg_rdata_o <= {23'h00_0000, flush_wake, flush_sensor};
        `REG_WATERMARK:    reg_rdata_o <= {15'h0000, wm_wake, wm_level};
        `REG_STATUS:       reg_rdata_o <= {13'h0000, init_sent, flush_pend, ovf_pend, loss_cnt};
        default:           reg_rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      flush_pend   <= 1'b0;
      flush_sensor <= 8'h00;
      flush_wake   <= 1'b0;
    end else if (reg_we_i && (reg_addr_i == `REG_FLUSH)) begin
      flush_pend   <= 1'b1; // [RQ4]
      flush_sensor <= reg_wdata_i[7:0];
      flush_wake   <= reg_wdata_i[`FLUSH_WAKE_BIT];
    end else if (take && (next_job == fifo_meta_event_pkg::JOB_FLUSH)) begin
      flush_pend <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wm_armed <= 1'b1;
    end else if (take && (next_job == fifo_meta_event_pkg::JOB_WM)) begin
      wm_armed <= 1'b0;
    end else if (fifo_level_i < wm_level) begin
      wm_armed <= 1'b1;
    end
  end

  assign sum_loss = {1'b0, (take && (next_job == fifo_meta_event_pkg::JOB_OVF)) ? 16'h0000 : loss_cnt} +
                    {1'b0, lost_bytes_i};

  // A loss in the cycle the count is handed out starts the next count instead of vanishing.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ovf_pend <= 1'b0;
      ovf_wake <= 1'b0;
      loss_cnt <= 16'h0000;
    end else if (data_lost_i) begin
      ovf_pend <= 1'b1;
      ovf_wake <= ovf_wake_i;
      loss_cnt <= sum_loss[16] ? `LOSS_MAX : sum_loss[15:0]; // [RQ10]
    end else if (take && (next_job == fifo_meta_event_pkg::JOB_OVF)) begin
      ovf_pend <= 1'b0;
      loss_cnt <= 16'h0000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      discard_o       <= 1'b0;
      discard_bytes_o <= 16'h0000;
    end else begin
      discard_o       <= data_lost_i && !ovf_pend; // [RQ12]
      discard_bytes_o <= `DISCARD_BYTES;
    end
  end

  always_comb begin
    sel_wake = ovf_wake;
    case (next_job)
      fifo_meta_event_pkg::JOB_FLUSH: sel_wake = flush_wake;
      fifo_meta_event_pkg::JOB_WM:    sel_wake = wm_wake;
      fifo_meta_event_pkg::JOB_EVT:   sel_wake = ev_i.wake;
      fifo_meta_event_pkg::JOB_ST:    sel_wake = st_i.wake;
      default: ;
    endcase
  end

  assign sel_en  = sel_wake ? wake_en : nwake_en;
  assign sel_irq = sel_wake ? wake_irq_en : nwake_irq_en;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      init_sent <= 1'b0;
    end else if (take && (next_job == fifo_meta_event_pkg::JOB_INIT)) begin
      init_sent <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state      <= fifo_meta_event_pkg::ST_IDLE;
      job        <= fifo_meta_event_pkg::JOB_NONE;
      seq        <= '{fifo_meta_event_pkg::REC_NONE, fifo_meta_event_pkg::REC_NONE, fifo_meta_event_pkg::REC_NONE};
      job_wake   <= 1'b0;
      job_ts     <= 32'h0000_0000;
      job_type   <= 8'h00;
      job_b1     <= 8'h00;
      job_b2     <= 8'h00;
      job_irq    <= 1'b0;
      rec_sr     <= 32'h0000_0000;
      rec_left   <= 3'd0;
      rec_is_evt <= 1'b0;
    end else begin
      case (state)
        fifo_meta_event_pkg::ST_IDLE: begin
          if (take) begin
            state    <= fifo_meta_event_pkg::ST_LOAD;
            job      <= next_job;
            job_ts   <= cur_ts_i;
            job_irq  <= 1'b0;
            case (next_job)
              fifo_meta_event_pkg::JOB_INIT: begin
                job_wake <= 1'b0;
                job_type <= `EV_INITIALIZED;
                job_b1   <= ram_version_i[7:0];
                job_b2   <= ram_version_i[15:8];
                job_irq  <= mask_bit(nwake_irq_en, `EV_INITIALIZED);
                seq      <= '{fifo_meta_event_pkg::REC_HI, fifo_meta_event_pkg::REC_LO,
                              mask_bit(nwake_en, `EV_INITIALIZED) ? fifo_meta_event_pkg::REC_EVT
                                                                  : fifo_meta_event_pkg::REC_NONE}; // [RQ3]
              end
              fifo_meta_event_pkg::JOB_OVF: begin
                job_wake <= ovf_wake;
                job_type <= `EV_OVERFLOW;
                job_b1   <= loss_cnt[7:0]; // [RQ10]
                job_b2   <= loss_cnt[15:8];
                job_irq  <= mask_bit(sel_irq, `EV_OVERFLOW);
                seq      <= '{mask_bit(sel_en, `EV_OVERFLOW) ? fifo_meta_event_pkg::REC_EVT
                                                             : fifo_meta_event_pkg::REC_NONE,
                              fifo_meta_event_pkg::REC_HI, fifo_meta_event_pkg::REC_LO}; // [RQ11] [RQ20]
              end
              fifo_meta_event_pkg::JOB_FLUSH: begin
                job_wake <= flush_wake;
                job_type <= `EV_FLUSH_DONE;
                job_b1   <= flush_sensor; // [RQ4]
                job_b2   <= 8'h00;
                job_irq  <= mask_bit(sel_irq, `EV_FLUSH_DONE);
                seq[0]   <= mask_bit(sel_en, `EV_FLUSH_DONE) ? fifo_meta_event_pkg::REC_EVT
                                                            : fifo_meta_event_pkg::REC_NONE;
              end
              fifo_meta_event_pkg::JOB_WM: begin
                job_wake <= wm_wake;
                job_type <= `EV_WATERMARK;
                job_b1   <= fifo_level_i[7:0]; // [RQ14]
                job_b2   <= fifo_level_i[15:8];
                job_irq  <= mask_bit(sel_irq, `EV_WATERMARK);
                seq[0]   <= mask_bit(sel_en, `EV_WATERMARK) ? fifo_meta_event_pkg::REC_EVT
                                                           : fifo_meta_event_pkg::REC_NONE;
              end
              fifo_meta_event_pkg::JOB_EVT: begin
                job_wake <= ev_i.wake;
                job_type <= ev_i.etype; // [RQ5] [RQ6] [RQ7] [RQ9] [RQ13]
                job_b1   <= ev_i.b1;
                job_b2   <= ev_i.b2;
                job_irq  <= mask_bit(sel_irq, ev_i.etype); // [RQ2]
                seq[0]   <= (gen_type_ok(ev_i.etype) && mask_bit(sel_en, ev_i.etype))
                            ? fifo_meta_event_pkg::REC_EVT : fifo_meta_event_pkg::REC_NONE; // [RQ1] [RQ22]
              end
              fifo_meta_event_pkg::JOB_ST: begin
                job_wake <= st_i.wake;
                job_type <= `EV_SELF_TEST;
                job_b1   <= st_i.sensor;
                job_b2   <= {5'h00, st_i.fail}; // [RQ16]
                job_irq  <= mask_bit(sel_irq, `EV_SELF_TEST);
                seq[0]   <= (mask_bit(sel_en, `EV_SELF_TEST) &&
                             ((st_i.sensor == `ST_ID_ACCEL) || (st_i.sensor == `ST_ID_GYRO_UNCAL) ||
                              (st_i.sensor == `ST_ID_MAG_UNCAL)))
                            ? fifo_meta_event_pkg::REC_EVT : fifo_meta_event_pkg::REC_NONE; // [RQ15]
              end
              fifo_meta_event_pkg::JOB_SAMPLE: begin
                job_wake <= sample_i.wake;
                job_ts   <= sample_i.ts;
                seq      <= '{(!hi_valid[sample_i.wake] || (last_hi[sample_i.wake] != sample_i.ts[31:16]))
                              ? fifo_meta_event_pkg::REC_HI : fifo_meta_event_pkg::REC_NONE, // [RQ19]
                              (!lo_valid[sample_i.wake] || (last_lo[sample_i.wake] != sample_i.ts[15:0]))
                              ? fifo_meta_event_pkg::REC_LO : fifo_meta_event_pkg::REC_NONE, // [RQ18]
                              fifo_meta_event_pkg::REC_NONE};
              end
              default: ;
            endcase
          end
        end
        fifo_meta_event_pkg::ST_LOAD: begin
          seq <= '{seq[1], seq[2], fifo_meta_event_pkg::REC_NONE};
          case (seq[0])
            fifo_meta_event_pkg::REC_HI: begin
              rec_sr     <= {TS_HI_ID, job_ts[23:16], job_ts[31:24], 8'h00};
              rec_left   <= 3'd3;
              rec_is_evt <= 1'b0;
              state      <= fifo_meta_event_pkg::ST_SEND;
            end
            fifo_meta_event_pkg::REC_LO: begin
              rec_sr     <= {TS_LO_ID, job_ts[7:0], job_ts[15:8], 8'h00};
              rec_left   <= 3'd3;
              rec_is_evt <= 1'b0;
              state      <= fifo_meta_event_pkg::ST_SEND;
            end
            fifo_meta_event_pkg::REC_EVT: begin
              rec_sr     <= {job_wake ? META_WAKE_ID : META_NWAKE_ID, job_type, job_b1, job_b2};
              rec_left   <= 3'd4;
              rec_is_evt <= 1'b1;
              state      <= fifo_meta_event_pkg::ST_SEND;
            end
            default: begin
              if ((seq[1] == fifo_meta_event_pkg::REC_NONE) && (seq[2] == fifo_meta_event_pkg::REC_NONE)) begin
                state <= (job == fifo_meta_event_pkg::JOB_SAMPLE) ? fifo_meta_event_pkg::ST_GRANT
                                                                 : fifo_meta_event_pkg::ST_IDLE;
              end
            end
          endcase
        end
        fifo_meta_event_pkg::ST_SEND: begin
          if (out_ready_i) begin
            rec_sr   <= {rec_sr[23:0], 8'h00};
            rec_left <= rec_left - 3'd1;
            if (rec_left == 3'd1) begin
              state <= fifo_meta_event_pkg::ST_LOAD;
            end
          end
        end
        fifo_meta_event_pkg::ST_GRANT: begin
          state <= fifo_meta_event_pkg::ST_IDLE;
        end
        default: state <= fifo_meta_event_pkg::ST_IDLE;
      endcase
    end
  end

  // Trackers follow what was really written, so forced records also reset the comparison.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      last_hi  <= '{16'h0000, 16'h0000};
      last_lo  <= '{16'h0000, 16'h0000};
      hi_valid <= 2'b00;
      lo_valid <= 2'b00;
    end else if (state == fifo_meta_event_pkg::ST_LOAD) begin
      if (seq[0] == fifo_meta_event_pkg::REC_HI) begin
        last_hi[job_wake]  <= job_ts[31:16]; // [RQ19]
        hi_valid[job_wake] <= 1'b1;
      end
      if (seq[0] == fifo_meta_event_pkg::REC_LO) begin
        last_lo[job_wake]  <= job_ts[15:0]; // [RQ18]
        lo_valid[job_wake] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      host_irq_o <= 1'b0;
    end else begin
      host_irq_o <= send_done && rec_is_evt && job_irq; // [RQ21] [RQ2]
    end
  end

  assign out_valid_o = (state == fifo_meta_event_pkg::ST_SEND);
  assign out_o.wake  = job_wake;
  assign out_o.data  = rec_sr[31:24];
  assign out_o.last  = (rec_left == 3'd1);

endmodule : fifo_meta_event_inserter

// File: testbench/fifo_meta_event_sva.sv
`timescale 1ns/100ps
module fifo_meta_event_sva (
  input wire logic                           clk_i,
  input wire logic                           rst_n_i,
  input wire logic                           reg_re_i,
  input wire logic [31:0]                    reg_rdata_o,
  input wire logic                           ev_ready_o,
  input wire logic                           st_ready_o,
  input wire logic                           sample_ready_o,
  input wire logic                           out_valid_o,
  input wire logic                           out_ready_i,
  input wire fifo_meta_event_pkg::out_byte_t out_o,
  input wire logic                           discard_o,
  input wire logic [15:0]                    discard_bytes_o,
  input wire logic                           host_irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_rdata_quiet: assert property (!$past(reg_re_i) |-> reg_rdata_o == 32'h0000_0000) else $error("rdata not zero");
  a_discard_size: assert property (discard_o |-> discard_bytes_o == 16'h00C8) else $error("bad discard size");
  a_discard_pulse: assert property (discard_o |=> !discard_o) else $error("discard too long");
  a_out_hold: assert property (out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_o)) else $error("byte lost");
  a_grant_pulse: assert property (sample_ready_o |=> !sample_ready_o) else $error("grant too long");
  a_grant_quiet: assert property (sample_ready_o |-> !out_valid_o) else $error("byte in grant");
  a_irq_pulse: assert property (host_irq_o |=> !host_irq_o) else $error("irq too long");
  a_one_job: assert property (ev_ready_o |-> !st_ready_o && !sample_ready_o) else $error("two jobs");
  a_rec_end: assert property (out_o.last && out_ready_i |=> !out_valid_o) else $error("overrun");
  c_irq: cover property (host_irq_o);
  c_discard: cover property (discard_o);
  c_grant: cover property (sample_ready_o);
endmodule : fifo_meta_event_sva
bind fifo_meta_event_inserter fifo_meta_event_sva sva_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_re_i(reg_re_i),
  .reg_rdata_o(reg_rdata_o), .ev_ready_o(ev_ready_o), .st_ready_o(st_ready_o), .sample_ready_o(sample_ready_o),
  .out_valid_o(out_valid_o), .out_ready_i(out_ready_i), .out_o(out_o), .discard_o(discard_o),
  .discard_bytes_o(discard_bytes_o), .host_irq_o(host_irq_o));

// File: testbench/fifo_meta_sink.sv
`timescale 1ns/100ps
module fifo_meta_sink (
  input  wire logic                           clk_i,
  input  wire fifo_meta_event_pkg::out_byte_t byte_i,
  input  wire logic                           valid_i,
  output logic                                ready_o
);
  logic [1:0] cyc = 2'h0;
  logic [7:0] got[$];
  initial ready_o = 1'b0;
  always @(posedge clk_i) begin
    cyc <= cyc + 2'h1;
    ready_o <= (cyc != 2'h3);
    if (valid_i && ready_o) got.push_back(byte_i.data);
  end
endmodule : fifo_meta_sink

// File: testbench/fifo_meta_event_inserter_bench.sv
`timescale 1ns/100ps
module fifo_meta_event_inserter_bench;
  logic clk_i = 0, rst_n_i = 0, reg_we_i = 0, reg_re_i = 0, init_done_i = 0, ev_valid_i = 0, st_valid_i = 0;
  logic sample_valid_i = 0, data_lost_i = 0, ovf_wake_i = 0, host_reading_i = 0, out_ready_i;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0000_0000, cur_ts_i = 32'hAABB_CCDD, reg_rdata_o;
  logic [15:0] ram_version_i = 16'h1234, lost_bytes_i = 16'h012C, fifo_level_i = 16'h0000, discard_bytes_o;
  fifo_meta_event_pkg::ev_req_t ev_i = '0;
  fifo_meta_event_pkg::self_test_t st_i = '0;
  fifo_meta_event_pkg::sample_req_t sample_i = '0;
  fifo_meta_event_pkg::out_byte_t out_o;
  logic ev_ready_o, st_ready_o, sample_ready_o, discard_o, out_valid_o, host_irq_o;
  int fail_count = 0, comparisons = 0, irqs = 0, discards = 0;
  logic [7:0] xq[$];
  fifo_meta_event_inserter fifo_meta_event_inserter_inst (.*);
  fifo_meta_sink fifo_meta_sink_inst (.clk_i(clk_i), .byte_i(out_o), .valid_i(out_valid_o), .ready_o(out_ready_i));
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    irqs <= irqs + int'(host_irq_o === 1'b1);
    discards <= discards + int'(discard_o === 1'b1);
  end
  task chk(input string what, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr_i <= a; reg_wdata_i <= d; reg_we_i <= 1'b1;
    @(posedge clk_i); reg_we_i <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e);
    reg_addr_i <= a; reg_re_i <= 1'b1;
    @(posedge clk_i); reg_re_i <= 1'b0;
    @(negedge clk_i); chk("rdata", e, reg_rdata_o);
    @(posedge clk_i);
  endtask : rd
  task take(input int k);
    case (k) 0: ev_valid_i <= 1'b1; 1: st_valid_i <= 1'b1; default: sample_valid_i <= 1'b1; endcase
    @(negedge clk_i); while ({sample_ready_o, st_ready_o, ev_ready_o} == 3'h0) @(negedge clk_i);
    @(posedge clk_i); {sample_valid_i, st_valid_i, ev_valid_i} <= 3'h0;
  endtask : take
  task stream(input string what);
    int n;
    n = 0;
    while (fifo_meta_sink_inst.got.size() < xq.size() && n < 300) begin @(posedge clk_i); n++; end
    repeat (20) @(posedge clk_i);
    chk({what, " count"}, 32'(xq.size()), 32'(fifo_meta_sink_inst.got.size()));
    foreach (xq[k]) chk(what, xq[k], fifo_meta_sink_inst.got[k]);
    fifo_meta_sink_inst.got.delete();
  endtask : stream
  task evt(input logic [24:0] r, input logic on);
    ev_i <= r;
    take(0);
    xq = {};
    if (on) xq = '{r[24] ? 8'hF2 : 8'hF3, r[23:16], r[15:8], r[7:0]};
    stream("event");
  endtask : evt
  task wrap_up;
    $display("Mismatches %0d of %0d comparisons", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (6000) @(posedge clk_i);
    fail_count++;
    wrap_up;
  end
  initial begin
    repeat (3) @(posedge clk_i); rst_n_i <= 1'b1;
    rd(8'h00, 32'h0001_B816); rd(8'h04, 32'h0001_0810); rd(8'h08, 32'h0001_A816);
    rd(8'h0C, 32'h0001_8810); rd(8'h40, 32'h0000_0000);
    init_done_i <= 1'b1;
    xq = '{8'hF0, 8'hBB, 8'hAA, 8'hF1, 8'hDD, 8'hCC, 8'hF3, 8'h10, 8'h34, 8'h12}; stream("init");
    wr(8'h10, 32'h0000_0105);
    xq = '{8'hF2, 8'h01, 8'h05, 8'h00}; stream("flush");
    evt({1'b0, 8'h04, 8'h5A, 8'hA5}, 1'b1);
    evt({1'b1, 8'h0B, 8'h03, 8'h02}, 1'b1);
    evt({1'b1, 8'h02, 8'h09, 8'h00}, 1'b1);
    evt({1'b0, 8'h0D, 8'h01, 8'h00}, 1'b1);
    evt({1'b0, 8'h03, 8'h07, 8'h01}, 1'b0);
    evt({1'b0, 8'h07, 8'h07, 8'h01}, 1'b0);
    wr(8'h08, 32'h0001_E81E);
    evt({1'b0, 8'h03, 8'h07, 8'h01}, 1'b1);
    fifo_level_i <= 16'h0040; wr(8'h14, 32'h0000_0030);
    xq = '{8'hF3, 8'h0E, 8'h40, 8'h00}; stream("watermark");
    st_i <= {1'b0, 8'h10, 3'h5}; take(1);
    xq = '{8'hF3, 8'h0F, 8'h10, 8'h05}; stream("self test");
    sample_i <= {1'b1, 32'h0001_0002}; take(2);
    xq = '{8'hF0, 8'h01, 8'h00, 8'hF1, 8'h02, 8'h00}; stream("sample");
    sample_i <= {1'b1, 32'h0001_0003}; take(2);
    xq = '{8'hF1, 8'h03, 8'h00}; stream("sample");
    sample_i <= {1'b1, 32'h0002_0003}; take(2);
    xq = '{8'hF0, 8'h02, 8'h00}; stream("sample");
    host_reading_i <= 1'b1; ovf_wake_i <= 1'b1; cur_ts_i <= 32'h0005_0006; data_lost_i <= 1'b1;
    @(posedge clk_i); data_lost_i <= 1'b0;
    xq = '{8'hF2, 8'h0C, 8'h2C, 8'h01, 8'hF0, 8'h05, 8'h00, 8'hF1, 8'h06, 8'h00}; stream("overflow");
    chk("discards", 1, discards);
    chk("irqs", 4, irqs);
    wrap_up;
  end
endmodule : fifo_meta_event_inserter_bench
